// >>> idfw_defines.vh
`ifndef IDFW_DEFINES_VH
`define IDFW_DEFINES_VH
// Register offsets
`define IDFW_REG_DIN       4'h0
`define IDFW_REG_DOUT      4'h1
`define IDFW_REG_FILT_EN   4'h2
`define IDFW_REG_FILT_DIV  4'h3
`define IDFW_REG_RISE_EN   4'h4
`define IDFW_REG_FALL_EN   4'h5
`define IDFW_REG_CHG_STAT  4'h6
`define IDFW_REG_PWRUP     4'h7
`define IDFW_REG_SAFE      4'h8
`define IDFW_REG_WD_CTRL   4'h9
`define IDFW_REG_WD_TOUT   4'ha
`define IDFW_REG_WD_STAT   4'hb
// Field positions
`define IDFW_CHG_BIT       0
`define IDFW_OVF_BIT       1
`define IDFW_WD_EN_BIT     0
`define IDFW_WD_KICK_BIT   1
`define IDFW_WD_EXP_BIT    0
// Reset values
`define IDFW_PWRUP_RST     8'h00
`define IDFW_SAFE_RST      8'h00
`define IDFW_FILT_DIV_RST  32'h000001f4
`define IDFW_WD_TOUT_RST   32'hffffffff
// Timing
`define IDFW_CLK_NS        25
`define IDFW_SAMPLE_NS     100
`define IDFW_SAMPLE_CYC    (`IDFW_SAMPLE_NS / `IDFW_CLK_NS)
`define IDFW_PWRUP_MS      400
`define IDFW_PWRUP_CYC     (`IDFW_PWRUP_MS * 1000000 / `IDFW_CLK_NS)
`endif

// >>> idfw_tick.v
`timescale 1ns/1ps
`include "idfw_defines.vh"
module idfw_tick (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        resetn,
  // Divider
  input  wire        en,
  input  wire [31:0] period,
  output reg         tick_q
);
  reg [31:0] cnt_q;
  always @(posedge clk_sys) begin
    if (!resetn || !en) begin
      cnt_q  <= 32'h00000000;
      tick_q <= 1'b0;
    end else if (cnt_q + 32'h00000001 >= period) begin
      cnt_q  <= 32'h00000000;
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 32'h00000001;
      tick_q <= 1'b0;
    end
  end
endmodule

// >>> idfw_filter.v
`timescale 1ns/1ps
module idfw_filter (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       resetn,
  // Timing enables
  input  wire       samp_tick,
  input  wire       filt_tick,
  // Lines
  input  wire [7:0] raw,
  input  wire [7:0] filt_en,
  output wire [7:0] level
);
  reg [7:0] samp_q;
  reg [7:0] cand_q;
  reg [7:0] filt_q;
  integer i;
  always @(posedge clk_sys) begin
    if (!resetn) begin
      samp_q <= 8'h00;
      cand_q <= 8'h00;
      filt_q <= 8'h00;
    end else begin
      if (samp_tick)
        samp_q <= raw;
      if (filt_tick) begin
        for (i = 0; i < 8; i = i + 1) begin
          // Accept only a level seen on two filter edges in a row
          if (samp_q[i] == cand_q[i])
            filt_q[i] <= cand_q[i];
          cand_q[i] <= samp_q[i];
        end
      end
    end
  end
  assign level = (filt_en & filt_q) | (~filt_en & samp_q);
endmodule

// >>> idfw_top.v
// Contract
// - Reject pulses under half interval, pass full
// - Per-line filter enable, shared 100us-200ms interval
// - Sample inputs every 100 ns
// - Counter makes filter clock, half interval
// - New level held two filter edges
// - Falling edges filtered like rising
// - Pass delay up to one filter interval
// - Changeover relays default deenergized
// - Single-throw relays default deenergized
// - Per-relay configurable power-up state
// - Power-up states applied within 400 ms
// - Per-line change detect raises interrupt
// - Separate rising and falling enables
// - Interrupt does not name line or direction
// - Overflow on edge before handling done
// - Monitored lines unreadable until interrupt
// - Timeout forces outputs to safe state
// - Safe state held until disarm+write, reset; relays leave it on disarm alone
// - Expired flag holds, writes except watchdog control and change acknowledge ignored until disarm
// - Watchdog counts 100 ns steps, 32 bits
// - Registers reached through mapped base address
`timescale 1ns/1ps
`include "idfw_defines.vh"
module idfw_top (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        resetn,
  // Register port
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata_q,
  // Field lines
  input  wire [7:0]  din_pins,
  output reg  [7:0]  relay_q,
  // Status
  output reg         chg_irq_q,
  output reg         wd_expired_q
);
  localparam [31:0] PWRUP_CYC = `IDFW_PWRUP_CYC;

  // Pin synchroniser
  reg  [7:0]  sync1_q;
  reg  [7:0]  sync2_q;
  always @(posedge clk_sys) begin
    if (!resetn) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end else begin
      sync1_q <= din_pins;
      sync2_q <= sync1_q;
    end
  end

  // Registers
  reg  [7:0]  filt_en_q;
  reg  [31:0] filt_div_q;
  reg  [7:0]  rise_en_q;
  reg  [7:0]  fall_en_q;
  reg  [7:0]  pwrup_q;
  reg  [7:0]  safe_q;
  reg  [7:0]  dout_q;
  reg         wd_en_q;
  reg  [31:0] wd_tout_q;
  reg  [31:0] wd_cnt_q;
  reg  [31:0] pu_cnt_q;
  reg         pu_done_q;
  reg         chg_q;
  reg         ovf_q;
  reg  [7:0]  prev_q;
  reg         read_ok_q;

  wire        wr_hit_dout = reg_wr && reg_addr == `IDFW_REG_DOUT;
  wire        wr_wd_ctrl  = reg_wr && reg_addr == `IDFW_REG_WD_CTRL;
  wire        kick        = wr_wd_ctrl && reg_wdata[`IDFW_WD_KICK_BIT];
  wire        disarm      = wr_wd_ctrl && !reg_wdata[`IDFW_WD_EN_BIT];
  wire        ack = reg_wr && reg_addr == `IDFW_REG_CHG_STAT;

  // Timing enables
  wire        samp_tick;
  wire        filt_tick;
  idfw_tick u_samp (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .en      (1'b1),
    .period  (`IDFW_SAMPLE_CYC),
    .tick_q  (samp_tick)
  );
  idfw_tick u_filt (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .en      (1'b1),
    .period  (filt_div_q),
    .tick_q  (filt_tick)
  );

  // Filter
  wire [7:0]  level;
  idfw_filter u_filter (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .samp_tick (samp_tick),
    .filt_tick (filt_tick),
    .raw       (sync2_q),
    .filt_en   (filt_en_q),
    .level     (level)
  );

  // Edge detection
  wire [7:0]  rise = level & ~prev_q & rise_en_q;
  wire [7:0]  fall = ~level & prev_q & fall_en_q;
  wire        any_edge = |(rise | fall);
  wire [7:0]  mon = rise_en_q | fall_en_q;

  always @(posedge clk_sys) begin
    if (!resetn) begin
      prev_q    <= 8'h00;
      chg_q     <= 1'b0;
      ovf_q     <= 1'b0;
      chg_irq_q <= 1'b0;
      read_ok_q <= 1'b0;
    end else begin
      prev_q <= level;
      // Change set wins over acknowledge; acknowledge clears overflow
      if (any_edge) begin
        chg_q <= 1'b1;
        if (chg_q && !ack)
          ovf_q <= 1'b1;
        else if (ack)
          ovf_q <= 1'b0;
      end else if (ack) begin
        chg_q <= 1'b0;
        ovf_q <= 1'b0;
      end
      chg_irq_q <= any_edge || (chg_q && !ack);
      if (any_edge)
        read_ok_q <= 1'b1;
    end
  end

  // Watchdog and outputs
  always @(posedge clk_sys) begin
    if (!resetn) begin
      filt_en_q    <= 8'h00;
      filt_div_q   <= `IDFW_FILT_DIV_RST;
      rise_en_q    <= 8'h00;
      fall_en_q    <= 8'h00;
      pwrup_q      <= `IDFW_PWRUP_RST;
      safe_q       <= `IDFW_SAFE_RST;
      dout_q       <= 8'h00;
      wd_en_q      <= 1'b0;
      wd_tout_q    <= `IDFW_WD_TOUT_RST;
      wd_cnt_q     <= 32'h00000000;
      wd_expired_q <= 1'b0;
      relay_q      <= 8'h00;
      pu_cnt_q     <= 32'h00000000;
      pu_done_q    <= 1'b0;
    end else begin
      if (reg_wr && !wd_expired_q) begin
        case (reg_addr)
          `IDFW_REG_FILT_EN:  filt_en_q  <= reg_wdata[7:0];
          `IDFW_REG_FILT_DIV: filt_div_q <= reg_wdata;
          `IDFW_REG_RISE_EN:  rise_en_q  <= reg_wdata[7:0];
          `IDFW_REG_FALL_EN:  fall_en_q  <= reg_wdata[7:0];
          `IDFW_REG_PWRUP:    pwrup_q    <= reg_wdata[7:0];
          `IDFW_REG_SAFE:     safe_q     <= reg_wdata[7:0];
          `IDFW_REG_WD_TOUT:  wd_tout_q  <= reg_wdata;
          default: ;
        endcase
      end
      if (wr_hit_dout && !wd_expired_q)
        dout_q <= reg_wdata[7:0];
      if (wr_wd_ctrl)
        wd_en_q <= reg_wdata[`IDFW_WD_EN_BIT];
      // Power-up hold applies programmed states
      if (!pu_done_q) begin
        if (pu_cnt_q + 32'h00000001 >= PWRUP_CYC)
          pu_done_q <= 1'b1;
        pu_cnt_q <= pu_cnt_q + 32'h00000001;
        dout_q   <= pwrup_q;
      end
      // Watchdog in 100 ns steps
      if (disarm) begin
        wd_expired_q <= 1'b0;
        wd_cnt_q     <= 32'h00000000;
      end else if (!wd_en_q || kick) begin
        wd_cnt_q <= 32'h00000000;
      end else if (samp_tick && !wd_expired_q) begin
        if (wd_cnt_q + 32'h00000001 >= wd_tout_q)
          wd_expired_q <= 1'b1;
        wd_cnt_q <= wd_cnt_q + 32'h00000001;
      end
      if (wd_expired_q)
        relay_q <= safe_q;
      else
        relay_q <= dout_q;
    end
  end

  // Register reads
  always @(posedge clk_sys) begin
    if (!resetn) begin
      reg_rdata_q <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `IDFW_REG_DIN:
          reg_rdata_q <= {24'h000000,
                          level & (read_ok_q ? 8'hff : ~mon)};
        `IDFW_REG_DOUT:     reg_rdata_q <= {24'h000000, dout_q};
        `IDFW_REG_FILT_EN:  reg_rdata_q <= {24'h000000, filt_en_q};
        `IDFW_REG_FILT_DIV: reg_rdata_q <= filt_div_q;
        `IDFW_REG_RISE_EN:  reg_rdata_q <= {24'h000000, rise_en_q};
        `IDFW_REG_FALL_EN:  reg_rdata_q <= {24'h000000, fall_en_q};
        `IDFW_REG_CHG_STAT: reg_rdata_q <= {30'h00000000, ovf_q, chg_q};
        `IDFW_REG_PWRUP:    reg_rdata_q <= {24'h000000, pwrup_q};
        `IDFW_REG_SAFE:     reg_rdata_q <= {24'h000000, safe_q};
        `IDFW_REG_WD_CTRL:  reg_rdata_q <= {31'h00000000, wd_en_q};
        `IDFW_REG_WD_TOUT:  reg_rdata_q <= wd_tout_q;
        `IDFW_REG_WD_STAT:  reg_rdata_q <= {31'h00000000, wd_expired_q};
        default:            reg_rdata_q <= 32'h00000000;
      endcase
    end else begin
      reg_rdata_q <= 32'h00000000;
    end
  end
endmodule

// >>> idfw_properties.sv
`timescale 1ns/1ps
module idfw_properties (
  // Clock and reset
  input wire        clk_sys,
  input wire        resetn,
  // Register port
  input wire [3:0]  reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata_q,
  // Field lines
  input wire [7:0]  din_pins,
  input wire [7:0]  relay_q,
  // Status
  input wire        chg_irq_q,
  input wire        wd_expired_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_q == 32'h0)
    else $error("read data not idle");
  a_exp_hold: assert property (wd_expired_q && !(reg_wr &&
    reg_addr == 4'h9 && !reg_wdata[0]) |=> wd_expired_q)
    else $error("expired flag dropped");
  a_safe_hold: assert property (wd_expired_q [*4] |-> $stable(relay_q))
    else $error("relays moved while expired");
  a_irq_sticky: assert property (chg_irq_q &&
    !(reg_wr && reg_addr == 4'h6) |=> chg_irq_q)
    else $error("change flag dropped");
  a_wd_clear: assert property (reg_wr && reg_addr == 4'h9 &&
    !reg_wdata[0] |=> ##[0:2] !wd_expired_q)
    else $error("disarm left flag set");
  a_stat_read: assert property (reg_rd && reg_addr == 4'hb &&
    wd_expired_q ##1 wd_expired_q |-> reg_rdata_q[0])
    else $error("expired status misread");
  a_chg_read: assert property (reg_rd && reg_addr == 4'h6 &&
    chg_irq_q ##1 chg_irq_q |-> reg_rdata_q[0])
    else $error("change status misread");
  a_relay_reset: assert property ($rose(resetn) |-> relay_q == 8'h00 &&
    !chg_irq_q && !wd_expired_q)
    else $error("outputs not cleared by reset");
  c_irq: cover property ($rose(chg_irq_q));
  c_exp: cover property ($rose(wd_expired_q));
  c_din: cover property (reg_rd && reg_addr == 4'h0);
endmodule
bind idfw_top idfw_properties i_idfw_properties (.clk_sys(clk_sys),
  .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
  .din_pins(din_pins), .relay_q(relay_q), .chg_irq_q(chg_irq_q),
  .wd_expired_q(wd_expired_q));

// >>> idfw_host.sv
`timescale 1ns/1ps
module idfw_host (
  // Clock
  input  wire         clk_sys,
  // Register port
  output logic [3:0]  reg_addr,
  output logic [31:0] reg_wdata,
  output logic        reg_wr,
  output logic        reg_rd,
  input  wire  [31:0] reg_rdata_q
);
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One-cycle write strobe
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Data taken the cycle after the strobe
  task rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_q;
  endtask
endmodule

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
  typedef struct {logic [3:0] a; logic [31:0] d; logic [31:0] e;} idfw_row_t;
  logic        clk_sys, resetn;
  logic [7:0]  din_pins;
  wire  [3:0]  reg_addr;
  wire  [31:0] reg_wdata, reg_rdata_q;
  wire         reg_wr, reg_rd, chg_irq_q, wd_expired_q;
  wire  [7:0]  relay_q;
  int          mismatches, checks;
  idfw_row_t   rows [8] = '{'{4'h2, 32'h01, 32'h01}, '{4'h3, 32'h08, 32'h08},
    '{4'h4, 32'h03, 32'h03}, '{4'h5, 32'h06, 32'h06},
    '{4'h7, 32'ha5, 32'ha5}, '{4'h8, 32'h3c, 32'h3c},
    '{4'ha, 32'h05, 32'h05}, '{4'hf, 32'h5a, 32'h00}};
  idfw_host i_idfw_host (.clk_sys(clk_sys), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q));
  idfw_top i_idfw_top (.clk_sys(clk_sys), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .din_pins(din_pins),
    .relay_q(relay_q), .chg_irq_q(chg_irq_q), .wd_expired_q(wd_expired_q));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task rdchk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] v;
    i_idfw_host.rd(a, v);
    chk(v, e);
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task final_report;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    #200000;
    mismatches++;
    final_report;
  end
  initial begin
    resetn = 1'b0;
    din_pins = 8'h00;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    rdchk(4'h3, 32'h1f4);
    rdchk(4'ha, 32'hffffffff);
    chk(relay_q, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      i_idfw_host.wr(rows[i].a, rows[i].d);
      rdchk(rows[i].a, rows[i].e);
    end
    chk(relay_q, 8'ha5);
    $display("test registers done");
    din_pins <= 8'h84;
    wt(20);
    chk(chg_irq_q, 1'b0);
    rdchk(4'h0, 32'h80);
    din_pins <= 8'h85;
    wt(6);
    din_pins <= 8'h84;
    wt(40);
    chk(chg_irq_q, 1'b0);
    din_pins <= 8'h85;
    for (int k = 0; k < 100 && chg_irq_q !== 1'b1; k++) wt(1);
    chk(chg_irq_q, 1'b1);
    din_pins <= 8'h87;
    wt(10);
    rdchk(4'h6, 32'h3);
    rdchk(4'h0, 32'h87);
    i_idfw_host.wr(4'h6, 32'h0);
    wt(3);
    chk(chg_irq_q, 1'b0);
    rdchk(4'h6, 32'h0);
    din_pins <= 8'h83;
    for (int k = 0; k < 20 && chg_irq_q !== 1'b1; k++) wt(1);
    chk(chg_irq_q, 1'b1);
    i_idfw_host.wr(4'h6, 32'h0);
    $display("test change done");
    i_idfw_host.wr(4'h9, 32'h1);
    wt(8);
    i_idfw_host.wr(4'h9, 32'h3);
    wt(8);
    i_idfw_host.wr(4'h9, 32'h3);
    wt(4);
    chk(wd_expired_q, 1'b0);
    for (int k = 0; k < 60 && wd_expired_q !== 1'b1; k++) wt(1);
    chk(wd_expired_q, 1'b1);
    wt(1);
    chk(relay_q, 8'h3c);
    i_idfw_host.wr(4'h1, 32'hff);
    i_idfw_host.wr(4'h8, 32'h00);
    wt(4);
    chk(relay_q, 8'h3c);
    rdchk(4'hb, 32'h1);
    i_idfw_host.wr(4'h9, 32'h0);
    wt(3);
    chk(wd_expired_q, 1'b0);
    rdchk(4'hb, 32'h0);
    $display("test watchdog done");
    resetn <= 1'b0;
    wt(3);
    resetn <= 1'b1;
    wt(2);
    chk(relay_q, 8'h00);
    $display("test second reset done");
    final_report;
  end
endmodule
